// ==== logic/trc_pkg.sv ====
// Constants shared by the tone receiver configuration block.
package trc_pkg;
  // Register byte offsets on the Wishbone bus.
  localparam logic [7:0] ROW_TOL_OFS  = 8'h00;
  localparam logic [7:0] COL_MODE_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS   = 8'h08;
  localparam logic [7:0] MASK_OFS     = 8'h0c;
  localparam logic [7:0] PRES_CNT_OFS = 8'h10;
  localparam logic [7:0] ABS_CNT_OFS  = 8'h14;
  localparam logic [7:0] STATE_OFS    = 8'h18;

  // Reset values.
  localparam logic [3:0] ROW_TOL_RST  = 4'h0;
  localparam logic [6:0] COL_MODE_RST = 7'h00;
  localparam logic [2:0] MASK_RST     = 3'h0;

  // Field positions inside the column/mode register.
  localparam int TOL_LSB       = 0;
  localparam int TONE_ONLY_BIT = 4;
  localparam int PT_RESET_BIT  = 5;
  localparam int AT_HOLD_BIT   = 6;

  // Status and mask bit positions and field width.
  localparam int EV_TONE      = 0;
  localparam int EV_ALERT_ON  = 1;
  localparam int EV_ALERT_OFF = 2;
  localparam int EV_W         = 3;

  // Accepted error in tenths of a percent.
  localparam logic [5:0] ROW_PM_TIGHT = 6'h06;
  localparam logic [5:0] ROW_PM_MID   = 6'h19;
  localparam logic [5:0] ROW_PM_WIDE  = 6'h23;
  localparam logic [5:0] COL_PM_TIGHT = 6'h05;
  localparam logic [5:0] COL_PM_MID   = 6'h0f;
  localparam logic [5:0] COL_PM_WIDE  = 6'h19;
  localparam int PM_SCALE = 1000;

  // Timing, in nanoseconds, and the derived cycle counts.
  localparam int CLK_NS         = 4;
  localparam int PRES_MIN_NS    = 500000;
  localparam int PRES_MAX_NS    = 10000000;
  localparam int ABS_MIN_NS     = 100000;
  localparam int ABS_MAX_NS     = 8000000;
  localparam int PRES_MIN_CYC   = (PRES_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRES_MAX_CYC   = PRES_MAX_NS / CLK_NS;
  localparam int ABS_MIN_CYC    = (ABS_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int ABS_MAX_CYC    = ABS_MAX_NS / CLK_NS;
endpackage

// ==== logic/trc_tol_check.sv ====
// Four-period tolerance check of one tone group against its nominal length.
`timescale 1ns/10ps
`default_nettype none
module trc_tol_check #(
  parameter int   PW     = 20,
  parameter logic IS_ROW = 1'b1
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          valid_i,
  input  wire logic [PW-1:0] period_i,
  input  wire logic [PW-1:0] nominal_i,
  input  wire logic [3:0]    code_i,
  output logic               done_o,
  output logic               ok_o
);
  localparam int XW = PW + 10;

  // Reserved codes fall back to the tightest limit.
  function automatic logic [5:0] limit_pm(input logic [3:0] c);
    logic [5:0] r;
    r = IS_ROW ? trc_pkg::ROW_PM_TIGHT : trc_pkg::COL_PM_TIGHT;
    if (c == 4'h1) begin
      r = IS_ROW ? trc_pkg::ROW_PM_MID : trc_pkg::COL_PM_MID;
    end else if (c[3:1] == 3'h1) begin
      r = IS_ROW ? trc_pkg::ROW_PM_WIDE : trc_pkg::COL_PM_WIDE;
    end
    return r;
  endfunction

  logic [PW-1:0] diff;
  logic [XW-1:0] lhs;
  logic [XW-1:0] rhs;

  always_comb begin
    diff = (period_i > nominal_i) ? period_i - nominal_i
                                  : nominal_i - period_i;
    lhs  = XW'(diff) * XW'(trc_pkg::PM_SCALE);
    rhs  = XW'(nominal_i) * XW'(limit_pm(code_i));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o <= 1'b0;
      ok_o   <= 1'b0;
    end else begin
      done_o <= valid_i;
      if (valid_i) begin
        ok_o <= (lhs <= rhs) && (nominal_i != '0);
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/trc_top.sv ====
// Tone receiver configuration, qualification counters and register file.
`timescale 1ns/10ps
`default_nettype none
module trc_top #(
  parameter int PW       = 20,
  parameter int CW       = 22,
  parameter int PRES_THR = trc_pkg::PRES_MIN_CYC,
  parameter int ABS_THR  = trc_pkg::ABS_MIN_CYC
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  // Wishbone classic slave.
  input  wire logic          wb_cyc_i,
  input  wire logic          wb_stb_i,
  input  wire logic          wb_we_i,
  input  wire logic [7:0]    wb_adr_i,
  input  wire logic [3:0]    wb_sel_i,
  input  wire logic [31:0]   wb_dat_i,
  output logic [31:0]        wb_dat_o,
  output logic               wb_ack_o,
  // Four-period measurements from the front end.
  input  wire logic          meas_valid_i,
  input  wire logic [PW-1:0] row_period_i,
  input  wire logic [PW-1:0] row_nominal_i,
  input  wire logic [1:0]    row_index_i,
  input  wire logic [PW-1:0] col_period_i,
  input  wire logic [PW-1:0] col_nominal_i,
  input  wire logic [1:0]    col_index_i,
  // Detection results.
  output logic               tone_detected_o,
  output logic [3:0]         tone_code_o,
  output logic               alert_present_o,
  output logic               irq_o
);
  localparam logic [CW-1:0] CNT_MAX = '1;
  localparam logic [CW-1:0] PRES_T  = CW'(PRES_THR);
  localparam logic [CW-1:0] ABS_T   = CW'(ABS_THR);

  // Idle has no tone. Tone has seen one that is not yet qualified as an alert.
  // Alert reports presence. Fade times the absence, and the report stays up
  // until that absence is qualified.
  typedef enum logic [1:0] {
    TRC_IDLE,
    TRC_TONE,
    TRC_ALERT,
    TRC_FADE
  } trc_state_t;

  logic [3:0]          row_tol_q;
  logic [6:0]          col_mode_q;
  logic [trc_pkg::EV_W-1:0] status_q;
  logic [trc_pkg::EV_W-1:0] mask_q;
  logic [CW-1:0]       pres_cnt_q;
  logic [CW-1:0]       abs_cnt_q;
  logic                tone_q;
  logic [3:0]          code_q;
  logic [3:0]          pend_code_q;
  logic                ack_q;
  logic [31:0]         rdat_q;
  trc_state_t          state_q;
  trc_state_t          state_d;

  logic                row_done;
  logic                row_ok;
  logic                col_done;
  logic                col_ok;
  logic                tone_d;
  logic                freq_change;
  logic                alert_on;
  logic                alert_off;
  logic                tone_rise;
  logic                bus_req;
  logic                wr_en;
  logic                wr_row;
  logic                wr_col;
  logic                wr_mask;
  logic                wr_status;
  logic [trc_pkg::EV_W-1:0] ev_set;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  // Both groups share one strobe, so their results arrive in the same cycle
  // and can be combined without further alignment.
  // Row group limit decode and compare.
  trc_tol_check #(
    .PW     (PW),
    .IS_ROW (1'b1)
  ) u_row (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .valid_i   (meas_valid_i),
    .period_i  (row_period_i),
    .nominal_i (row_nominal_i),
    .code_i    (row_tol_q),
    .done_o    (row_done),
    .ok_o      (row_ok)
  );

  // Column group limit decode and compare.
  trc_tol_check #(
    .PW     (PW),
    .IS_ROW (1'b0)
  ) u_col (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .valid_i   (meas_valid_i),
    .period_i  (col_period_i),
    .nominal_i (col_nominal_i),
    .code_i    (col_mode_q[trc_pkg::TOL_LSB+:4]),
    .done_o    (col_done),
    .ok_o      (col_ok)
  );

  // Single tone mode needs either group, dual mode needs both.
  always_comb begin
    if (col_mode_q[trc_pkg::TONE_ONLY_BIT]) begin
      tone_d = row_ok | col_ok;
    end else begin
      tone_d = row_ok & col_ok;
    end
  end

  // Indices are captured with the measurement so they line up with the
  // compare results one cycle later.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_code_q <= 4'h0;
    end else if (meas_valid_i) begin
      pend_code_q <= {row_index_i, col_index_i};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tone_q <= 1'b0;
      code_q <= 4'h0;
    end else if (row_done && col_done) begin
      tone_q <= tone_d;
      if (tone_d) begin
        code_q <= pend_code_q;
      end
    end
  end

  assign freq_change = row_done && col_done && tone_d && tone_q &&
                       (pend_code_q != code_q);
  assign tone_rise   = row_done && col_done && tone_d && !tone_q;

  // Present-time counter: only ever counts up, saturating at full scale.
  // Clearing it on loss of tone keeps a stale count from qualifying a
  // later and shorter tone.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pres_cnt_q <= '0;
    end else if (!tone_q) begin
      pres_cnt_q <= '0;
    end else if (freq_change && col_mode_q[trc_pkg::PT_RESET_BIT]) begin
      pres_cnt_q <= '0;
    end else if (pres_cnt_q != CNT_MAX) begin
      pres_cnt_q <= pres_cnt_q + 1'b1;
    end
  end

  // Absent-time counter runs only while an alert is being reported, so a
  // brief dropout inside a tone does not end the alert by itself.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      abs_cnt_q <= '0;
    end else if (state_q == TRC_IDLE || state_q == TRC_TONE) begin
      abs_cnt_q <= '0;
    end else if (!tone_q) begin
      if (abs_cnt_q != CNT_MAX) begin
        abs_cnt_q <= abs_cnt_q + 1'b1;
      end
    end else if (!col_mode_q[trc_pkg::AT_HOLD_BIT]) begin
      if (abs_cnt_q != '0) begin
        abs_cnt_q <= abs_cnt_q - 1'b1;
      end
    end
    // With the hold bit set the count simply stays while tone is back.
  end

  // Comparing one below the threshold lets the state change land on the
  // edge at which the counter reaches it, so the report comes exactly the
  // threshold count of cycles after the tone was first qualified.
  assign alert_on  = (state_q == TRC_TONE) && tone_q &&
                     (pres_cnt_q >= PRES_T - 1'b1);
  assign alert_off = (state_q == TRC_FADE) && !tone_q &&
                     (abs_cnt_q >= ABS_T - 1'b1);

  // Qualification sequence for the alert report.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      TRC_IDLE: begin
        if (tone_q) begin
          state_d = TRC_TONE;
        end
      end
      TRC_TONE: begin
        if (!tone_q) begin
          state_d = TRC_IDLE;
        end else if (alert_on) begin
          state_d = TRC_ALERT;
        end
      end
      TRC_ALERT: begin
        if (!tone_q) begin
          state_d = TRC_FADE;
        end
      end
      TRC_FADE: begin
        if (alert_off) begin
          state_d = TRC_IDLE;
        end else if (tone_q && abs_cnt_q == '0) begin
          // Tone back with nothing left to count resumes the report
          // without a fresh presence wait.
          state_d = TRC_ALERT;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= TRC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Register bus: one wait state, ack drops the cycle after it is given.
  // Ack comes from a flop, so the read data it qualifies was latched on the
  // edge that raised ack and stands for the whole ack cycle. A write lands on the
  // edge at which the master samples ack, when the transfer completes.
  assign bus_req   = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_en     = wb_cyc_i && wb_stb_i && ack_q && wb_we_i &&
                     wb_sel_i[0];
  assign wr_row    = wr_en && hit(wb_adr_i, trc_pkg::ROW_TOL_OFS);
  assign wr_col    = wr_en && hit(wb_adr_i, trc_pkg::COL_MODE_OFS);
  assign wr_mask   = wr_en && hit(wb_adr_i, trc_pkg::MASK_OFS);
  assign wr_status = wr_en && hit(wb_adr_i, trc_pkg::STATUS_OFS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      row_tol_q <= trc_pkg::ROW_TOL_RST;
    end else if (wr_row) begin
      row_tol_q <= wb_dat_i[3:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      col_mode_q <= trc_pkg::COL_MODE_RST;
    end else if (wr_col) begin
      col_mode_q <= wb_dat_i[6:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= trc_pkg::MASK_RST;
    end else if (wr_mask) begin
      mask_q <= wb_dat_i[trc_pkg::EV_W-1:0];
    end
  end

  // Event strobes last one cycle by construction: each is tied to a state
  // change or to the first qualified measurement of a tone.
  always_comb begin
    ev_set = '0;
    ev_set[trc_pkg::EV_TONE]      = tone_rise;
    ev_set[trc_pkg::EV_ALERT_ON]  = alert_on;
    ev_set[trc_pkg::EV_ALERT_OFF] = alert_off;
  end

  // A new event in the same cycle as its write-one clear stays set, so no
  // event is ever lost to a clear that races it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_q <= '0;
    end else if (wr_status) begin
      status_q <= (status_q & ~wb_dat_i[trc_pkg::EV_W-1:0]) | ev_set;
    end else begin
      status_q <= status_q | ev_set;
    end
  end

  // Reserved and unmapped locations read as zero. Data is latched as the
  // request is taken.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (bus_req) begin
      rdat_q <= 32'h0000_0000;
      unique case (wb_adr_i)
        trc_pkg::ROW_TOL_OFS:  rdat_q[3:0] <= row_tol_q;
        trc_pkg::COL_MODE_OFS: rdat_q[6:0] <= col_mode_q;
        trc_pkg::STATUS_OFS:   rdat_q[trc_pkg::EV_W-1:0] <= status_q;
        trc_pkg::MASK_OFS:     rdat_q[trc_pkg::EV_W-1:0] <= mask_q;
        trc_pkg::PRES_CNT_OFS: rdat_q[CW-1:0] <= pres_cnt_q;
        trc_pkg::ABS_CNT_OFS:  rdat_q[CW-1:0] <= abs_cnt_q;
        trc_pkg::STATE_OFS:    rdat_q[5:0] <= {code_q, alert_present_o,
                                               tone_q};
        default:               rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  // Outputs come from flops or from the state register alone, so a bus
  // access never disturbs them.
  assign wb_ack_o        = ack_q;
  assign wb_dat_o        = rdat_q;
  assign tone_detected_o = tone_q;
  assign tone_code_o     = code_q;
  assign alert_present_o = (state_q == TRC_ALERT) || (state_q == TRC_FADE);
  assign irq_o           = |(status_q & mask_q);
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Register and detection testbench for the tone receiver block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int PW = 20;
  localparam int PRES_THR = 20;
  localparam int ABS_THR = 10;
  localparam logic [19:0] NOM = 20'h003e8;
  logic          clk_i;
  logic          rst_i;
  logic          wb_cyc_i;
  logic          wb_stb_i;
  logic          wb_we_i;
  logic [7:0]    wb_adr_i;
  logic [3:0]    wb_sel_i;
  logic [31:0]   wb_dat_i;
  logic [31:0]   wb_dat_o;
  logic          wb_ack_o;
  logic          meas_valid_i;
  logic [PW-1:0] row_period_i;
  logic [PW-1:0] row_nominal_i;
  logic [1:0]    row_index_i;
  logic [PW-1:0] col_period_i;
  logic [PW-1:0] col_nominal_i;
  logic [1:0]    col_index_i;
  logic          tone_detected_o;
  logic [3:0]    tone_code_o;
  logic          alert_present_o;
  logic          irq_o;
  logic [31:0]   q;
  int            n_mismatch = 0;
  int            comparisons = 0;
  trc_top #(.PRES_THR(PRES_THR), .ABS_THR(ABS_THR)) trc_top_inst (.clk_i,
    .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .meas_valid_i, .row_period_i, .row_nominal_i,
    .row_index_i, .col_period_i, .col_nominal_i, .col_index_i,
    .tone_detected_o, .tone_code_o, .alert_present_o, .irq_o);
  trc_front_model fe (.clk_i, .meas_valid_o(meas_valid_i),
    .row_period_o(row_period_i), .row_nominal_o(row_nominal_i),
    .row_index_o(row_index_i), .col_period_o(col_period_i),
    .col_nominal_o(col_nominal_i), .col_index_o(col_index_i));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1)
        break;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (i == 20) begin
      n_mismatch++;
      final_report();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    wb(1'b0, a, 32'h0);
    chk(q, x);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic burst(input int n, input logic ok);
    repeat (n) fe.send(NOM, NOM, ok ? NOM : 20'h0, 4'h9);
  endtask
  task automatic pres_run();
    fork
      for (int i = 0; i < 30; i++)
        fe.send(NOM, NOM, NOM, {1'b0, i[0], 2'b00});
      begin
        repeat (14) @(posedge clk_i);
        wb(1'b0, trc_pkg::PRES_CNT_OFS, 32'h0);
      end
    join
    burst(20, 1'b0);
  endtask
  function automatic int lim(input int g, input int c);
    if (c == 1)
      return g ? trc_pkg::COL_PM_MID : trc_pkg::ROW_PM_MID;
    if (c == 2 || c == 3)
      return g ? trc_pkg::COL_PM_WIDE : trc_pkg::ROW_PM_WIDE;
    return g ? trc_pkg::COL_PM_TIGHT : trc_pkg::ROW_PM_TIGHT;
  endfunction
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    n_mismatch++;
    final_report();
  end
  initial begin
    logic [19:0] p;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(trc_pkg::ROW_TOL_OFS, 32'h0);
    rd(trc_pkg::COL_MODE_OFS, 32'h0);
    wb(1'b1, trc_pkg::ROW_TOL_OFS, 32'hffff_ff0f);
    rd(trc_pkg::ROW_TOL_OFS, 32'hf);
    wb(1'b1, trc_pkg::COL_MODE_OFS, 32'hffff_ff7f);
    rd(trc_pkg::COL_MODE_OFS, 32'h7f);
    rd(8'h40, 32'h0);
    wb(1'b1, trc_pkg::COL_MODE_OFS, 32'h0);
    $display("test registers done");
    for (int g = 0; g < 2; g++) begin
      for (int c = 0; c < 16; c++) begin
        wb(1'b1, g ? trc_pkg::COL_MODE_OFS : trc_pkg::ROW_TOL_OFS, 32'(c));
        for (int e = lim(g, c); e < lim(g, c) + 2; e++) begin
          p = NOM + 20'(e);
          fe.send(g ? NOM : p, g ? p : NOM, NOM, 4'(c));
          fe.idle();
          settle(3);
          chk(32'(tone_detected_o), 32'(e == lim(g, c)));
          if (e == lim(g, c))
            chk(32'(tone_code_o), 32'(c));
        end
      end
    end
    for (int m = 1; m >= 0; m--) begin
      wb(1'b1, trc_pkg::COL_MODE_OFS, m ? 32'h10 : 32'h0);
      fe.send(NOM, NOM + 20'h00064, NOM, 4'h6);
      fe.idle();
      settle(3);
      chk(32'(tone_detected_o), 32'(m));
      chk(32'(tone_code_o), 32'h6);
    end
    wb(1'b1, trc_pkg::COL_MODE_OFS, 32'h0);
    $display("test tolerance done");
    wb(1'b1, trc_pkg::STATUS_OFS, 32'h7);
    burst(12, 1'b1);
    settle(1);
    chk(32'(alert_present_o), 32'h0);
    burst(28, 1'b1);
    settle(1);
    chk(32'(alert_present_o), 32'h1);
    rd(trc_pkg::STATUS_OFS, 32'h3);
    chk(32'(irq_o), 32'h0);
    wb(1'b1, trc_pkg::MASK_OFS, 32'h2);
    settle(1);
    chk(32'(irq_o), 32'h1);
    burst(5, 1'b0);
    burst(10, 1'b1);
    rd(trc_pkg::ABS_CNT_OFS, 32'h0);
    wb(1'b1, trc_pkg::COL_MODE_OFS, 32'h40);
    burst(5, 1'b0);
    burst(10, 1'b1);
    rd(trc_pkg::ABS_CNT_OFS, 32'h5);
    burst(20, 1'b0);
    settle(2);
    chk(32'(alert_present_o), 32'h0);
    rd(trc_pkg::STATUS_OFS, 32'h7);
    wb(1'b1, trc_pkg::STATUS_OFS, 32'h7);
    rd(trc_pkg::STATUS_OFS, 32'h0);
    chk(32'(irq_o), 32'h0);
    $display("test alert done");
    wb(1'b1, trc_pkg::COL_MODE_OFS, 32'h0);
    pres_run();
    chk(32'(q >= 32'h8), 32'h1);
    wb(1'b1, trc_pkg::COL_MODE_OFS, 32'h20);
    pres_run();
    chk(32'(q < 32'h4), 32'h1);
    $display("test counters done");
    final_report();
  end
endmodule
bind trc_top trc_top_sva #(.PW(PW), .PRES_THR(PRES_THR), .ABS_THR(ABS_THR))
  trc_top_sva_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .meas_valid_i, .row_period_i, .row_nominal_i, .row_index_i, .col_period_i,
  .col_nominal_i, .col_index_i, .tone_detected_o, .tone_code_o,
  .alert_present_o, .irq_o);
`default_nettype wire

// ==== verification/trc_front_model.sv ====
// Front-end model that hands four-period measurements to the block.
`timescale 1ns/10ps
`default_nettype none
module trc_front_model #(
  parameter int PW = 20
) (
  input  wire logic     clk_i,
  output logic          meas_valid_o,
  output logic [PW-1:0] row_period_o,
  output logic [PW-1:0] row_nominal_o,
  output logic [1:0]    row_index_o,
  output logic [PW-1:0] col_period_o,
  output logic [PW-1:0] col_nominal_o,
  output logic [1:0]    col_index_o
);
  initial begin
    {meas_valid_o, row_period_o, row_nominal_o, row_index_o} = '0;
    {col_period_o, col_nominal_o, col_index_o} = '0;
  end
  // Firmware is taken to hold the demodulator enable high for the whole
  // on-hook wait, so measurements may arrive at any time.
  task automatic send(input logic [PW-1:0] rp, cp, n, input logic [3:0] k);
    @(posedge clk_i);
    meas_valid_o  <= 1'b1;
    row_period_o  <= rp;
    col_period_o  <= cp;
    row_nominal_o <= n;
    col_nominal_o <= n;
    row_index_o   <= k[3:2];
    col_index_o   <= k[1:0];
  endtask
  // Idle period fields are inverted so a stale value is never mistaken for data.
  task automatic idle();
    @(posedge clk_i);
    meas_valid_o <= 1'b0;
    row_period_o <= ~row_period_o;
    col_period_o <= ~col_period_o;
  endtask
endmodule
`default_nettype wire

// ==== verification/trc_top_sva.sv ====
// Port-level assertions for the tone receiver configuration block.
`timescale 1ns/10ps
`default_nettype none
module trc_top_sva #(
  parameter int PW       = 20,
  parameter int PRES_THR = trc_pkg::PRES_MIN_CYC,
  parameter int ABS_THR  = trc_pkg::ABS_MIN_CYC
) (
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          wb_cyc_i,
  input wire logic          wb_stb_i,
  input wire logic          wb_ack_o,
  input wire logic          meas_valid_i,
  input wire logic [PW-1:0] row_period_i,
  input wire logic [PW-1:0] row_nominal_i,
  input wire logic [1:0]    row_index_i,
  input wire logic [PW-1:0] col_period_i,
  input wire logic [PW-1:0] col_nominal_i,
  input wire logic [1:0]    col_index_i,
  input wire logic          tone_detected_o,
  input wire logic [3:0]    tone_code_o,
  input wire logic          alert_present_o,
  input wire logic          irq_o
);
  default clocking dcb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Tone run lengths; run_q also restarts on a new code, so it never
  // overstates what a counter that resets on a frequency change has seen.
  int on_q;
  int run_q;
  int off_q;
  always_ff @(posedge clk_i) begin
    on_q  <= (rst_i || !tone_detected_o) ? 0 : on_q + 1;
    run_q <= (rst_i || !tone_detected_o || $changed(tone_code_o)) ?
             0 : run_q + 1;
    off_q <= (rst_i || tone_detected_o) ? 0 : off_q + 1;
  end
  sequence s_good;
    meas_valid_i && row_period_i == row_nominal_i && row_nominal_i != 0 &&
    col_period_i == col_nominal_i && col_nominal_i != 0;
  endsequence
  property p_rst;
    disable iff (1'b0) rst_i |=> !wb_ack_o && !irq_o && !tone_detected_o &&
      !alert_present_o;
  endproperty
  property p_ack_lat;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_accept;
    logic [3:0] c;
    (s_good, c = {row_index_i, col_index_i}) |->
      ##2 tone_detected_o && tone_code_o == c;
  endproperty
  property p_reject;
    meas_valid_i && row_nominal_i == 0 && col_nominal_i == 0 |->
      ##2 !tone_detected_o;
  endproperty
  property p_pres_early;
    $rose(alert_present_o) |-> on_q >= PRES_THR - 2;
  endproperty
  property p_pres_late;
    run_q == PRES_THR + 4 |-> alert_present_o;
  endproperty
  property p_abs_late;
    off_q == ABS_THR + 4 |-> !alert_present_o;
  endproperty
  a_rst: assert property (p_rst)
    else $error("outputs not cleared by reset");
  a_ack_lat: assert property (p_ack_lat)
    else $error("ack missing");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack too long");
  a_accept: assert property (p_accept)
    else $error("exact tone not accepted");
  a_reject: assert property (p_reject)
    else $error("zero nominal accepted");
  a_pres_early: assert property (p_pres_early)
    else $error("alert reported early");
  a_pres_late: assert property (p_pres_late)
    else $error("alert reported late");
  a_abs_late: assert property (p_abs_late)
    else $error("absence reported late");
endmodule
`default_nettype wire
